// >>> pkg/sofc_cfg.svh
// offsets, field positions, reset values and timing counts of the offset compensation block
`ifndef SOFC_CFG_SVH
`define SOFC_CFG_SVH
`define SOFC_ADDR_OFS_FIRST 8'h71
`define SOFC_ADDR_OFS_LAST 8'h77
`define SOFC_OFS_BYTES 7
`define SOFC_ADDR_STATUS 8'h7C
`define SOFC_ADDR_CMD 8'h7E
`define SOFC_CMD_START_FOC 8'h03
`define SOFC_CMD_PROG_NVM 8'hA0
`define SOFC_CMD_SOFTRESET 8'hB6
`define SOFC_CTL_BYTE 6
`define SOFC_BIT_GYR_EN 7
`define SOFC_BIT_ACC_EN 6
`define SOFC_STAT_BUSY 0
`define SOFC_STAT_FOC_DONE 1
`define SOFC_STAT_DROP 2
`define SOFC_OFS_RESET 8'h00
`define SOFC_ACC_OFS_W 8
`define SOFC_GYR_OFS_W 10
`define SOFC_FOC_LOG2 4
`define SOFC_FOC_SAMPLES 5'h10
`define SOFC_CLK_PERIOD_NS 20
`define SOFC_SRST_DELAY_NS 300000
`define SOFC_SRST_CYCLES ((`SOFC_SRST_DELAY_NS + `SOFC_CLK_PERIOD_NS - 1) / `SOFC_CLK_PERIOD_NS)
`endif

// >>> pkg/sofc_pkg.sv
// types shared by the offset compensation block
package sofc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_PROG = 3'b010,
    ST_FOC = 3'b011,
    ST_SRST = 3'b100
  } sofc_state_t;
  // one three-axis sample
  typedef struct packed {
    logic [15:0] z;
    logic [15:0] y;
    logic [15:0] x;
  } sofc_vec_t;
  // offset block image as held in non-volatile memory, byte 0 lowest
  typedef logic [55:0] sofc_img_t;
endpackage : sofc_pkg

// >>> hw/sofc_axis_add.sv
// one axis: scale an offset to the data word and add it with saturation
`timescale 1ns/1ns
module sofc_axis_add
  import sofc_pkg::*;
(
  // sample and correction
  input wire logic signed [15:0] i_data,
  input wire logic signed [9:0] i_ofs,
  input wire logic [2:0] i_shift,
  // corrected sample
  output logic signed [15:0] o_sum
);
  logic signed [22:0] ofs_ext;
  logic signed [23:0] sum_wide;

  // sign extension first, so a negative offset stays negative after the shift
  always_comb begin
    ofs_ext = 23'(signed'(i_ofs)) <<< i_shift;
    sum_wide = 24'(signed'(i_data)) + 24'(ofs_ext);
    if (sum_wide > 24'sh00_7FFF) begin
      o_sum = 16'sh7FFF;
    end else if (sum_wide < -24'sh00_8000) begin
      o_sum = -16'sh8000;
    end else begin
      o_sum = sum_wide[15:0];
    end
  end
endmodule : sofc_axis_add

// >>> hw/sofc_foc_axis.sv
// one axis of fast offset calibration: average, negate, scale, saturate
`timescale 1ns/1ns
`include "sofc_cfg.svh"
module sofc_foc_axis
  import sofc_pkg::*;
#(
  parameter int OFS_W = 10
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // accumulation control
  input wire logic i_clr,
  input wire logic i_add,
  input wire logic signed [15:0] i_sample,
  input wire logic [2:0] i_shift,
  // computed correction
  output logic signed [9:0] o_ofs
);
  localparam logic signed [16:0] LIM = 17'((1 << (OFS_W - 1)) - 1);
  logic signed [19:0] sum_q;
  logic signed [16:0] neg_avg;
  logic signed [16:0] scaled;

  // running sum of the pre-filtered samples
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sum_q <= 20'sh0_0000;
    end else if (i_clr) begin
      sum_q <= 20'sh0_0000;
    end else if (i_add) begin
      sum_q <= sum_q + 20'(i_sample);
    end
  end

  // target is zero on every axis, so the correction is minus the mean
  always_comb begin
    neg_avg = -17'(sum_q >>> `SOFC_FOC_LOG2);
    scaled = neg_avg >>> i_shift;
    if (scaled > LIM) begin
      o_ofs = 10'(LIM);
    end else if (scaled < -LIM - 17'sh0_0001) begin
      o_ofs = 10'(-LIM - 17'sh0_0001);
    end else begin
      o_ofs = 10'(scaled);
    end
  end
endmodule : sofc_foc_axis

// >>> hw/sofc_core.sv
// offset compensation: register block, nvm load/program, calibration and correction datapath
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
`include "sofc_cfg.svh"

// Overview of operation
// - enabled sensor corrects filtered and pre-filtered data
// - offsets are two's complement signed
// - accel offset 8 bit, 3.9 mg, range-independent
// - gyro offset 10 bit, 0.061 dps step
// - reload offsets from nvm after any reset
// - offset block can be programmed into nvm
// - software writes replace offset bytes
// - calibration result written into offsets automatically
// - seven bytes from 0x71, accel then gyro low
// - byte 6: enables and gyro upper bits
// - enable bit one corrects, zero passes through
// - command 0x03 runs fast offset calibration
// - command 0xA0 programs nvm backed registers
// - command 0xB6 resets, then reloads from nvm
module sofc_core
  import sofc_pkg::*;
#(
  parameter int SRST_CYCLES = `SOFC_SRST_CYCLES
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESETN,
  // register port
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [7:0] O_RDATA,
  // sensor data in, same clock
  input wire sofc_vec_t I_ACC_FILT,
  input wire sofc_vec_t I_GYR_FILT,
  input wire logic I_FILT_VLD,
  input wire sofc_vec_t I_ACC_PRE,
  input wire sofc_vec_t I_GYR_PRE,
  input wire logic I_PRE_VLD,
  input wire logic [2:0] I_ACC_SHIFT,
  input wire logic [2:0] I_GYR_SHIFT,
  // corrected sensor data out
  output sofc_vec_t O_ACC_FILT,
  output sofc_vec_t O_GYR_FILT,
  output logic O_FILT_VLD,
  output sofc_vec_t O_ACC_PRE,
  output sofc_vec_t O_GYR_PRE,
  output logic O_PRE_VLD,
  // non-volatile memory port
  output logic O_NVM_RD_REQ,
  input wire logic I_NVM_RD_ACK,
  input wire sofc_img_t I_NVM_RD_DATA,
  output logic O_NVM_WR_REQ,
  output sofc_img_t O_NVM_WR_DATA,
  input wire logic I_NVM_WR_ACK
);
  sofc_state_t state_q;
  logic [15:0] cnt_q;
  logic [4:0] foc_cnt_q;
  logic [7:0] ofs_q [`SOFC_OFS_BYTES];
  logic [7:0] rdata_q;
  logic rd_req_q;
  logic wr_req_q;
  sofc_img_t wr_data_q;
  logic foc_done_q;
  logic drop_q;
  logic filt_vld_q;
  logic pre_vld_q;
  logic signed [15:0] f_in [6];
  logic signed [15:0] p_in [6];
  logic signed [15:0] f_sum [6];
  logic signed [15:0] p_sum [6];
  logic signed [15:0] f_out_q [6];
  logic signed [15:0] p_out_q [6];
  logic signed [9:0] ofs_ax [6];
  logic signed [9:0] foc_ofs [6];
  logic [2:0] shift_ax [6];
  logic en_ax [6];
  logic cmd_wr;
  logic busy;
  logic srst_go;
  logic prog_go;
  logic foc_go;
  logic drop_now;
  logic foc_fin;
  logic load_fin;
  logic ofs_wr;
  logic [2:0] ofs_idx;
  logic gyr_en;
  logic acc_en;
  sofc_img_t img;

  // command decode; softreset is the only command taken while busy
  always_comb begin
    cmd_wr = I_WR && (I_ADDR == `SOFC_ADDR_CMD);
    busy = (state_q != ST_IDLE);
    srst_go = cmd_wr && (I_WDATA == `SOFC_CMD_SOFTRESET);
    prog_go = cmd_wr && !busy && (I_WDATA == `SOFC_CMD_PROG_NVM);
    foc_go = cmd_wr && !busy && (I_WDATA == `SOFC_CMD_START_FOC);
    drop_now = cmd_wr && busy && (I_WDATA != `SOFC_CMD_SOFTRESET);
    foc_fin = (state_q == ST_FOC) && (foc_cnt_q == `SOFC_FOC_SAMPLES);
    load_fin = (state_q == ST_LOAD) && I_NVM_RD_ACK;
    ofs_wr = I_WR && (I_ADDR >= `SOFC_ADDR_OFS_FIRST) && (I_ADDR <= `SOFC_ADDR_OFS_LAST);
    ofs_idx = 3'(I_ADDR - `SOFC_ADDR_OFS_FIRST);
  end

  // sequencer; power-on enters the softreset wait with one cycle left
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state_q <= ST_SRST;
      cnt_q <= 16'h0001;
    end else if (srst_go) begin
      state_q <= ST_SRST;
      cnt_q <= 16'(SRST_CYCLES);
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (prog_go) begin
            state_q <= ST_PROG;
          end else if (foc_go) begin
            state_q <= ST_FOC;
          end
        end
        ST_SRST: begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q <= 16'h0001) begin
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (I_NVM_RD_ACK) begin
            state_q <= ST_IDLE;
          end
        end
        ST_PROG: begin
          if (I_NVM_WR_ACK) begin
            state_q <= ST_IDLE;
          end
        end
        ST_FOC: begin
          if (foc_fin) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // nvm request pulses; the image is frozen when programming starts
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;
      wr_data_q <= '0;
    end else begin
      rd_req_q <= !srst_go && (state_q == ST_SRST) && (cnt_q <= 16'h0001);
      wr_req_q <= prog_go;
      if (prog_go) begin
        wr_data_q <= img;
      end
    end
  end

  // calibration sample counter
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      foc_cnt_q <= 5'h00;
    end else if (foc_go) begin
      foc_cnt_q <= 5'h00;
    end else if ((state_q == ST_FOC) && I_PRE_VLD && !foc_fin) begin
      foc_cnt_q <= foc_cnt_q + 5'h01;
    end
  end

  // offset bytes: softreset clears, nvm load beats calibration beats software
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      for (int i = 0; i < `SOFC_OFS_BYTES; i++) begin
        ofs_q[i] <= `SOFC_OFS_RESET;
      end
    end else if (srst_go) begin
      for (int i = 0; i < `SOFC_OFS_BYTES; i++) begin
        ofs_q[i] <= `SOFC_OFS_RESET;
      end
    end else if (load_fin) begin
      for (int i = 0; i < `SOFC_OFS_BYTES; i++) begin
        ofs_q[i] <= I_NVM_RD_DATA[8*i +: 8];
      end
    end else if (foc_fin) begin
      for (int i = 0; i < 3; i++) begin
        ofs_q[i] <= foc_ofs[i][7:0];
        ofs_q[i+3] <= foc_ofs[i+3][7:0];
      end
      // enables are kept, only the gyro upper bits change
      ofs_q[`SOFC_CTL_BYTE][5:0] <= {foc_ofs[5][9:8], foc_ofs[4][9:8], foc_ofs[3][9:8]};
    end else if (ofs_wr) begin
      ofs_q[ofs_idx] <= I_WDATA;
    end
  end

  // sticky status flags, cleared by reading status; a new event wins
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      foc_done_q <= 1'b0;
      drop_q <= 1'b0;
    end else begin
      if (foc_fin) begin
        foc_done_q <= 1'b1;
      end else if (I_RD && (I_ADDR == `SOFC_ADDR_STATUS)) begin
        foc_done_q <= 1'b0;
      end
      if (drop_now) begin
        drop_q <= 1'b1;
      end else if (I_RD && (I_ADDR == `SOFC_ADDR_STATUS)) begin
        drop_q <= 1'b0;
      end
    end
  end

  // read data one cycle after the strobe; unmapped and command read zero
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rdata_q <= 8'h00;
    end else if (I_RD) begin
      if ((I_ADDR >= `SOFC_ADDR_OFS_FIRST) && (I_ADDR <= `SOFC_ADDR_OFS_LAST)) begin
        rdata_q <= ofs_q[ofs_idx];
      end else if (I_ADDR == `SOFC_ADDR_STATUS) begin
        rdata_q <= {5'h00, drop_q, foc_done_q, busy};
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // field extraction: gyro offsets join upper bits from the control byte
  always_comb begin
    gyr_en = ofs_q[`SOFC_CTL_BYTE][`SOFC_BIT_GYR_EN];
    acc_en = ofs_q[`SOFC_CTL_BYTE][`SOFC_BIT_ACC_EN];
    for (int i = 0; i < 3; i++) begin
      ofs_ax[i] = 10'(signed'(ofs_q[i]));
      ofs_ax[i+3] = {ofs_q[`SOFC_CTL_BYTE][2*i +: 2], ofs_q[i+3]};
      shift_ax[i] = I_ACC_SHIFT;
      shift_ax[i+3] = I_GYR_SHIFT;
      en_ax[i] = acc_en;
      en_ax[i+3] = gyr_en;
      f_in[i] = I_ACC_FILT[16*i +: 16];
      f_in[i+3] = I_GYR_FILT[16*i +: 16];
      p_in[i] = I_ACC_PRE[16*i +: 16];
      p_in[i+3] = I_GYR_PRE[16*i +: 16];
    end
    for (int i = 0; i < `SOFC_OFS_BYTES; i++) begin
      img[8*i +: 8] = ofs_q[i];
    end
  end

  // per axis: two adders and one calibration accumulator
  for (genvar a = 0; a < 6; a++) begin : g_axis
    sofc_axis_add u_f_add (
      .i_data(f_in[a]),
      .i_ofs(ofs_ax[a]),
      .i_shift(shift_ax[a]),
      .o_sum(f_sum[a])
    );
    sofc_axis_add u_p_add (
      .i_data(p_in[a]),
      .i_ofs(ofs_ax[a]),
      .i_shift(shift_ax[a]),
      .o_sum(p_sum[a])
    );
    sofc_foc_axis #(
      .OFS_W((a < 3) ? `SOFC_ACC_OFS_W : `SOFC_GYR_OFS_W)
    ) u_foc (
      .i_clk(I_CORE_CLK),
      .i_resetn(I_RESETN),
      .i_clr(foc_go),
      .i_add((state_q == ST_FOC) && I_PRE_VLD && !foc_fin),
      .i_sample(p_in[a]),
      .i_shift(shift_ax[a]),
      .o_ofs(foc_ofs[a])
    );

    // corrected samples only when the sensor's enable bit is one
    always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
        f_out_q[a] <= 16'h0000;
        p_out_q[a] <= 16'h0000;
      end else begin
        if (I_FILT_VLD) begin
          f_out_q[a] <= en_ax[a] ? f_sum[a] : f_in[a];
        end
        if (I_PRE_VLD) begin
          p_out_q[a] <= en_ax[a] ? p_sum[a] : p_in[a];
        end
      end
    end
  end

  // output strobes are registered on the same edge as the data, one cycle after the input strobe
  always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      filt_vld_q <= 1'b0;
      pre_vld_q <= 1'b0;
    end else begin
      filt_vld_q <= I_FILT_VLD;
      pre_vld_q <= I_PRE_VLD;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_NVM_RD_REQ = rd_req_q;
  assign O_NVM_WR_REQ = wr_req_q;
  assign O_NVM_WR_DATA = wr_data_q;
  assign O_FILT_VLD = filt_vld_q;
  assign O_PRE_VLD = pre_vld_q;
  assign O_ACC_FILT = {f_out_q[2], f_out_q[1], f_out_q[0]};
  assign O_GYR_FILT = {f_out_q[5], f_out_q[4], f_out_q[3]};
  assign O_ACC_PRE = {p_out_q[2], p_out_q[1], p_out_q[0]};
  assign O_GYR_PRE = {p_out_q[5], p_out_q[4], p_out_q[3]};

  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESETN);

  sequence s_srst_cmd;
    I_WR && (I_ADDR == `SOFC_ADDR_CMD) && (I_WDATA == `SOFC_CMD_SOFTRESET);
  endsequence
  sequence s_prog_idle;
    I_WR && (I_ADDR == `SOFC_ADDR_CMD) && (I_WDATA == `SOFC_CMD_PROG_NVM) && (state_q == ST_IDLE);
  endsequence

  AST_PASS_THROUGH: assert property (I_PRE_VLD && !acc_en |=> O_ACC_PRE.x == $past(I_ACC_PRE.x))
    else $error("disabled accel data was altered");
  AST_ZERO_OFS: assert property (I_FILT_VLD && gyr_en && ofs_ax[4] == 10'h000 |=> O_GYR_FILT.y == $past(I_GYR_FILT.y))
    else $error("zero gyro offset changed data");
  AST_NO_WRAP: assert property (I_PRE_VLD && acc_en && !ofs_q[0][7] && !I_ACC_PRE.x[15]
    |=> !O_ACC_PRE.x[15] && (O_ACC_PRE.x >= $past(I_ACC_PRE.x)))
    else $error("positive sum wrapped or shrank");
  AST_SRST_RELOAD: assert property (s_srst_cmd ##1 !srst_go |-> state_q == ST_SRST && ofs_q[0] == 8'h00)
    else $error("softreset did not clear and wait");
  AST_RD_REQ: assert property (state_q == ST_SRST && cnt_q == 16'h0001 && !srst_go |=> O_NVM_RD_REQ && state_q == ST_LOAD)
    else $error("nvm load not requested");
  AST_LOAD_DATA: assert property (load_fin && !srst_go |=> ofs_q[6] == $past(I_NVM_RD_DATA[55:48]))
    else $error("nvm image not loaded");
  AST_PROG: assert property (s_prog_idle |=> O_NVM_WR_REQ && O_NVM_WR_DATA == $past(img) ##1 !O_NVM_WR_REQ)
    else $error("nvm program request wrong");
  AST_FOC_START: assert property (foc_go && !srst_go |=> state_q == ST_FOC && foc_cnt_q == 5'h00)
    else $error("calibration did not start");
  AST_SW_WRITE: assert property (ofs_wr && ofs_idx == 3'h1 && !srst_go && !load_fin && !foc_fin
    |=> ofs_q[1] == $past(I_WDATA))
    else $error("software write lost");
  // a running sequence may still end on its own, but a dropped command starts nothing
  AST_DROP: assert property (drop_now
    |=> drop_q && (state_q == $past(state_q) || state_q == ST_IDLE || state_q == ST_LOAD))
    else $error("busy command not dropped");
endmodule : sofc_core

// >>> sim/tb_sensor_offset_compensation.sv
// self-checking bench for the offset compensation block against a queue-free integer model
`timescale 1ns/1ns
`include "sofc_cfg.svh"
module tb_sensor_offset_compensation
  import sofc_pkg::*;
  ;
  logic clk;
  logic resetn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic wr;
  logic rd;
  sofc_vec_t acc_f, gyr_f, acc_p, gyr_p, o_acc_f, o_gyr_f, o_acc_p, o_gyr_p;
  logic filt_vld, pre_vld, o_filt_vld, o_pre_vld;
  logic [2:0] ash;
  logic [2:0] gsh;
  logic nvm_rd_req, nvm_rd_ack, nvm_wr_req, nvm_wr_ack;
  sofc_img_t nvm_rd_data, nvm_wr_data, img;
  int errors;
  int n_checks;
  logic [7:0] ofs [7]; // model of the offset bytes

  // short softreset wait count keeps the soft reset walk brief
  sofc_core #(.SRST_CYCLES(4)) dut_u (
    .I_CORE_CLK(clk), .I_RESETN(resetn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .I_ACC_FILT(acc_f), .I_GYR_FILT(gyr_f), .I_FILT_VLD(filt_vld),
    .I_ACC_PRE(acc_p), .I_GYR_PRE(gyr_p), .I_PRE_VLD(pre_vld), .I_ACC_SHIFT(ash), .I_GYR_SHIFT(gsh),
    .O_ACC_FILT(o_acc_f), .O_GYR_FILT(o_gyr_f), .O_FILT_VLD(o_filt_vld), .O_ACC_PRE(o_acc_p),
    .O_GYR_PRE(o_gyr_p), .O_PRE_VLD(o_pre_vld), .O_NVM_RD_REQ(nvm_rd_req), .I_NVM_RD_ACK(nvm_rd_ack),
    .I_NVM_RD_DATA(nvm_rd_data), .O_NVM_WR_REQ(nvm_wr_req), .O_NVM_WR_DATA(nvm_wr_data),
    .I_NVM_WR_ACK(nvm_wr_ack)
  );

  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // data is looked at only in the one cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_reg

  task automatic rd_all();
    for (int i = 0; i < 7; i++) rd_reg(8'(`SOFC_ADDR_OFS_FIRST + i), ofs[i]);
  endtask : rd_all

  task automatic wait_req(input bit w);
    int k;
    k = 0;
    // the request pulse may stand right after the strobe's own edge
    #1;
    while ((w ? nvm_wr_req : nvm_rd_req) !== 1'b1 && k < 40) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(w ? nvm_wr_req : nvm_rd_req, 1'b1);
  endtask : wait_req

  // answer one load request; data turned over once the ack is gone
  task automatic nvm_load(input sofc_img_t im);
    wait_req(1'b0);
    @(posedge clk);
    nvm_rd_ack <= 1'b1;
    nvm_rd_data <= im;
    @(posedge clk);
    nvm_rd_ack <= 1'b0;
    nvm_rd_data <= ~im;
    for (int i = 0; i < 7; i++) ofs[i] = im[8*i+:8];
    repeat (2) @(posedge clk);
  endtask : nvm_load

  // expected corrected vector: sign-extend, scale, saturate
  function automatic sofc_vec_t expv(input sofc_vec_t d, input bit gy);
    sofc_vec_t r;
    int s;
    int o;
    logic signed [9:0] g10;
    for (int i = 0; i < 3; i++) begin
      g10 = {ofs[6][2*i+:2], ofs[3+i]};
      o = gy ? int'(g10) : int'($signed(ofs[i]));
      s = int'($signed(d[16*i+:16]));
      if (ofs[6][gy ? 7 : 6]) s = s + o * (1 << (gy ? gsh : ash));
      if (s > 32767) s = 32767;
      if (s < -32768) s = -32768;
      r[16*i+:16] = 16'(s);
    end
    return r;
  endfunction : expv

  // both streams at once; accel x axes pinned at the limits to reach saturation
  task automatic sample();
    sofc_vec_t a, g, ap, gp;
    a = 48'({$urandom(), $urandom()});
    g = 48'({$urandom(), $urandom()});
    ap = 48'({$urandom(), $urandom()});
    gp = 48'({$urandom(), $urandom()});
    a[15:0] = 16'h7FFF;
    ap[15:0] = 16'h8000;
    @(posedge clk);
    {acc_f, gyr_f, acc_p, gyr_p} <= {a, g, ap, gp};
    filt_vld <= 1'b1;
    pre_vld <= 1'b1;
    @(posedge clk);
    filt_vld <= 1'b0;
    pre_vld <= 1'b0;
    {acc_f, gyr_f, acc_p, gyr_p} <= ~{a, g, ap, gp};
    #1;
    chk({o_filt_vld, o_pre_vld}, 2'b11);
    chk(o_acc_f, expv(a, 1'b0));
    chk(o_acc_p, expv(ap, 1'b0));
    chk(o_gyr_f, expv(g, 1'b1));
    chk(o_gyr_p, expv(gp, 1'b1));
  endtask : sample

  // hang guard, far beyond the expected run length
  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial begin
    logic [7:0] b;
    errors = 0;
    n_checks = 0;
    resetn = 1'b0;
    {addr, wdata, wr, rd, filt_vld, pre_vld, nvm_rd_ack, nvm_wr_ack} = '0;
    {acc_f, gyr_f, acc_p, gyr_p, nvm_rd_data} = '0;
    ash = 3'h3;
    gsh = 3'h0;
    void'($urandom(13));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    // power-on load of a random image, then the byte map
    img = 56'({$urandom(), $urandom()});
    nvm_load(img);
    rd_all();
    rd_reg(8'h70, 8'h00);
    rd_reg(`SOFC_ADDR_CMD, 8'h00);
    // every enable combination with fresh software offsets and scalings
    for (int e = 0; e < 4; e++) begin
      for (int i = 0; i < 7; i++) begin
        b = 8'($urandom());
        if (i == 6) b[7:6] = 2'(e);
        // last round: positive accel x, zero gyro y, so both data checks see their case
        if (e == 3 && i == 0) b[7] = 1'b0;
        if (e == 3 && i == 4) b = 8'h00;
        if (e == 3 && i == 6) b[3:2] = 2'b00;
        wr_reg(8'(`SOFC_ADDR_OFS_FIRST + i), b);
        ofs[i] = b;
      end
      rd_all();
      @(posedge clk);
      ash <= 3'(3 + $urandom_range(3));
      gsh <= 3'($urandom_range(4));
      repeat (4) sample();
    end
    // program nvm; a command while busy is dropped and flagged
    wr_reg(`SOFC_ADDR_CMD, `SOFC_CMD_PROG_NVM);
    wait_req(1'b1);
    for (int i = 0; i < 7; i++) img[8*i+:8] = ofs[i];
    chk(nvm_wr_data, img);
    wr_reg(`SOFC_ADDR_CMD, `SOFC_CMD_START_FOC);
    @(posedge clk);
    nvm_wr_ack <= 1'b1;
    @(posedge clk);
    nvm_wr_ack <= 1'b0;
    rd_reg(`SOFC_ADDR_STATUS, 8'h04);
    rd_reg(`SOFC_ADDR_STATUS, 8'h00);
    // an unknown code while idle starts nothing and is not flagged
    wr_reg(`SOFC_ADDR_CMD, 8'h5A);
    rd_reg(`SOFC_ADDR_STATUS, 8'h00);
    // calibration on constant samples; two axes driven into saturation
    @(posedge clk);
    ash <= 3'h3;
    gsh <= 3'h0;
    wr_reg(`SOFC_ADDR_CMD, `SOFC_CMD_START_FOC);
    repeat (2) @(posedge clk);
    repeat (16) begin
      @(posedge clk);
      acc_p <= {16'hFFC0, 16'h0028, 16'h4000};
      gyr_p <= {16'h0003, 16'hFF9C, 16'h07D0};
      pre_vld <= 1'b1;
      @(posedge clk);
      pre_vld <= 1'b0;
    end
    repeat (4) @(posedge clk);
    {ofs[2], ofs[1], ofs[0]} = {8'h08, 8'hFB, 8'h80};
    {ofs[5], ofs[4], ofs[3]} = {8'hFD, 8'h64, 8'h00};
    ofs[6][5:0] = 6'h32;
    rd_all();
    rd_reg(`SOFC_ADDR_STATUS, 8'h02);
    sample();
    // soft reset aborts a running calibration, clears, then reloads a new image
    img = 56'({$urandom(), $urandom()});
    wr_reg(`SOFC_ADDR_CMD, `SOFC_CMD_START_FOC);
    wr_reg(`SOFC_ADDR_CMD, `SOFC_CMD_SOFTRESET);
    fork
      nvm_load(img);
      begin
        rd_reg(`SOFC_ADDR_OFS_LAST, 8'h00);
        rd_reg(`SOFC_ADDR_OFS_FIRST, 8'h00);
      end
    join
    rd_all();
    rd_reg(`SOFC_ADDR_STATUS, 8'h00);
    sample();
    give_verdict();
  end
endmodule : tb_sensor_offset_compensation
